// File: include/sleep_ctrl_pkg.sv
// constants shared by the sleep controller interrupt ends
package sleep_ctrl_pkg;
  localparam int          NUM_MODULES       = 41;
  localparam int          ADDR_W            = 12;
  localparam logic [11:0] OFS_PID           = 12'h000;
  localparam logic [11:0] OFS_REEVAL        = 12'h018;
  localparam logic [11:0] OFS_MOD_PEND_LO   = 12'h040;
  localparam logic [11:0] OFS_MOD_PEND_HI   = 12'h044;
  localparam logic [11:0] OFS_MOD_CLR_LO    = 12'h050;
  localparam logic [11:0] OFS_MOD_CLR_HI    = 12'h054;
  localparam logic [11:0] OFS_DOM_PEND      = 12'h060;
  localparam logic [11:0] OFS_DOM_CLR       = 12'h068;
  localparam logic [11:0] OFS_TRANS_CMD     = 12'h120;
  localparam logic [11:0] OFS_TRANS_STAT    = 12'h128;
  localparam logic [11:0] OFS_DOM_STAT      = 12'h200;
  localparam logic [11:0] OFS_DOM_CTRL      = 12'h300;
  localparam logic [11:0] OFS_MOD_STAT      = 12'h800;
  localparam logic [11:0] OFS_MOD_CTRL      = 12'ha00;
  localparam int          HI_BITS           = 9;
  // bit positions inside the re-evaluate, per-domain and per-module words
  localparam int          BIT_REEVAL        = 0;
  localparam int          BIT_DOM_PEND      = 0;
  localparam int          BIT_STATE_EN      = 9;
  localparam int          BIT_RESET_EN      = 10;
  localparam int          BIT_STATE_STAT    = 16;
  localparam int          BIT_RESET_STAT    = 17;
  localparam int          BIT_EXT_STAT      = 18;
  // identification fields; values are arbitrary
  localparam logic [1:0]  PID_SCHEME        = 2'h1;
  localparam logic [11:0] PID_FAMILY        = 12'h0_0a5;
  localparam logic [4:0]  PID_RTL           = 5'h00;
  localparam logic [2:0]  PID_MAJOR         = 3'h1;
  localparam logic [1:0]  PID_CUSTOM        = 2'h0;
  localparam logic [5:0]  PID_MINOR         = 6'h00;
  // host command registers on apb
  localparam logic [7:0]  HOFS_ADDR         = 8'h00;
  localparam logic [7:0]  HOFS_WDATA        = 8'h04;
  localparam logic [7:0]  HOFS_CTRL         = 8'h08;
  localparam logic [7:0]  HOFS_STATUS       = 8'h0c;
  localparam logic [7:0]  HOFS_RDATA        = 8'h10;
  localparam int          HBIT_START        = 0;
  localparam int          HBIT_WRITE        = 1;
  localparam int          HBIT_BUSY         = 0;
  localparam int          HBIT_IRQ          = 1;
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_REQ  = 3'b010,
    H_DONE = 3'b100
  } host_state_t;
endpackage

// File: include/sleep_ctrl_if.sv
// register port and interrupt line between controller and host side
`timescale 1ns/100ps
interface sleep_ctrl_if;
  logic        req;
  logic        we;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;
  logic        sleep_ctrl_irq;
  modport device (input req, we, addr, wdata, output rdata, ack, sleep_ctrl_irq);
  modport host (output req, we, addr, wdata, input rdata, ack, sleep_ctrl_irq);
endinterface

// File: rtl/sleep_ctrl_irq_dev.sv
// interrupt aggregation of the power and sleep controller
//
// Local design decision: the req/ack register port; the APB slave port is in the host end.
`timescale 1ns/100ps
module sleep_ctrl_irq_dev
  import sleep_ctrl_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  sleep_ctrl_if.device                link,
  input  wire logic                   dom_emu_evt_i,
  input  wire logic                   ext_power_evt_i,
  input  wire logic [NUM_MODULES-1:0] inhibit_sleep_i,
  input  wire logic [NUM_MODULES-1:0] leave_enable_i,
  input  wire logic [NUM_MODULES-1:0] force_active_i,
  input  wire logic [NUM_MODULES-1:0] module_enabled_i,
  input  wire logic [NUM_MODULES-1:0] local_reset_evt_i,
  output logic                        trans_go_o
);
  import sleep_ctrl_pkg::*;

  logic [NUM_MODULES-1:0] state_en;
  logic [NUM_MODULES-1:0] reset_en;
  logic [NUM_MODULES-1:0] state_stat;
  logic [NUM_MODULES-1:0] reset_stat;
  logic [NUM_MODULES-1:0] mod_pend;
  logic                   dom_state_en;
  logic                   dom_state_stat;
  logic                   dom_ext_stat;
  logic                   dom_pend;
  logic                   ack;
  logic [31:0]            rdata;
  logic                   irq;

  logic                   take;
  logic                   wr;
  logic [11:0]            a;
  logic [NUM_MODULES-1:0] state_evt;
  logic [NUM_MODULES-1:0] mod_set;
  logic [NUM_MODULES-1:0] mod_clr;
  logic [NUM_MODULES-1:0] mod_ctrl_sel;
  logic [NUM_MODULES-1:0] mod_stat_sel;
  logic                   dom_set;
  logic                   dom_clr;
  logic                   eval_now;
  logic                   any_active;
  logic [31:0]            next_rdata;

  assign take = link.req && !ack;
  assign wr   = take && link.we;
  assign a    = link.addr;

  // one word per module, aligned, from the array bases
  always_comb begin
    for (int m = 0; m < NUM_MODULES; m++) begin
      mod_ctrl_sel[m] = (a == OFS_MOD_CTRL + 12'(m * 4));
      mod_stat_sel[m] = (a == OFS_MOD_STAT + 12'(m * 4));
    end
  end

  assign state_evt = (inhibit_sleep_i & leave_enable_i)
                   | (force_active_i & ~module_enabled_i);
  assign mod_set   = (state_evt & state_en) | (local_reset_evt_i & reset_en);

  // clear masks from the two module clear words; a zero bit does nothing
  always_comb begin
    mod_clr = '0;
    if (wr && a == OFS_MOD_CLR_LO) begin
      mod_clr[31:0] = link.wdata;
    end
    if (wr && a == OFS_MOD_CLR_HI) begin
      mod_clr[NUM_MODULES-1:32] = link.wdata[HI_BITS-1:0];
    end
  end

  assign dom_set  = (dom_emu_evt_i && dom_state_en) || ext_power_evt_i;
  assign dom_clr  = wr && a == OFS_DOM_CLR && link.wdata[BIT_DOM_PEND];
  assign eval_now = wr && a == OFS_REEVAL && link.wdata[BIT_REEVAL];

  // control words: enables are the only stored bits
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_en     <= '0;
      reset_en     <= '0;
      dom_state_en <= 1'b0;
    end else begin
      for (int m = 0; m < NUM_MODULES; m++) begin
        if (wr && mod_ctrl_sel[m]) begin
          state_en[m] <= link.wdata[BIT_STATE_EN];
          reset_en[m] <= link.wdata[BIT_RESET_EN];
        end
      end
      if (wr && a == OFS_DOM_CTRL) begin
        dom_state_en <= link.wdata[BIT_STATE_EN];
      end
    end
  end

  // sticky status and pending; a new event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_stat <= '0;
      reset_stat <= '0;
      mod_pend   <= '0;
    end else begin
      state_stat <= (state_stat & ~mod_clr) | state_evt;
      reset_stat <= (reset_stat & ~mod_clr) | local_reset_evt_i;
      mod_pend   <= (mod_pend & ~mod_clr) | mod_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dom_state_stat <= 1'b0;
      dom_ext_stat   <= 1'b0;
      dom_pend       <= 1'b0;
    end else begin
      dom_state_stat <= (dom_state_stat && !dom_clr) || dom_emu_evt_i;
      dom_ext_stat   <= (dom_ext_stat && !dom_clr) || ext_power_evt_i;
      dom_pend       <= (dom_pend && !dom_clr) || dom_set;
    end
  end

  assign any_active = (|mod_pend) || dom_pend;

  // the evaluate write drops the line for one cycle so the host sees a new edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq <= 1'b0;
    end else begin
      irq <= any_active && !eval_now;
    end
  end

  // transition sequencing lives elsewhere; only the go strobe leaves here
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      trans_go_o <= 1'b0;
    end else begin
      trans_go_o <= wr && a == OFS_TRANS_CMD && link.wdata[0];
    end
  end

  // read mux; unmapped and write-only words read zero
  always_comb begin
    next_rdata = '0;
    if (a == OFS_PID) begin
      next_rdata = {PID_SCHEME, 2'b00, PID_FAMILY, PID_RTL,
                    PID_MAJOR, PID_CUSTOM, PID_MINOR};
    end else if (a == OFS_MOD_PEND_LO) begin
      next_rdata = mod_pend[31:0];
    end else if (a == OFS_MOD_PEND_HI) begin
      next_rdata[HI_BITS-1:0] = mod_pend[NUM_MODULES-1:32];
    end else if (a == OFS_DOM_PEND) begin
      next_rdata[BIT_DOM_PEND] = dom_pend;
    end else if (a == OFS_TRANS_STAT) begin
      next_rdata = '0;
    end else if (a == OFS_DOM_STAT) begin
      next_rdata[BIT_STATE_STAT] = dom_state_stat;
      next_rdata[BIT_EXT_STAT]   = dom_ext_stat;
    end else if (a == OFS_DOM_CTRL) begin
      next_rdata[BIT_STATE_EN] = dom_state_en;
    end else begin
      for (int m = 0; m < NUM_MODULES; m++) begin
        if (mod_stat_sel[m]) begin
          next_rdata[BIT_STATE_STAT] = state_stat[m];
          next_rdata[BIT_RESET_STAT] = reset_stat[m];
        end
        if (mod_ctrl_sel[m]) begin
          next_rdata[BIT_STATE_EN] = state_en[m];
          next_rdata[BIT_RESET_EN] = reset_en[m];
        end
      end
    end
  end

  // answer one cycle after the request; ack drops after one cycle even if the request stays
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack   <= 1'b0;
      rdata <= '0;
    end else begin
      ack <= take;
      if (take && !link.we) begin
        rdata <= next_rdata;
      end
    end
  end

  assign link.ack            = ack;
  assign link.rdata          = rdata;
  assign link.sleep_ctrl_irq = irq;

  // far side walks pending then status then clear, and
  // enables the line at its own controller
endmodule

// File: rtl/sleep_ctrl_irq_host.sv
// host end: apb command registers driving the controller register port
`timescale 1ns/100ps
module sleep_ctrl_irq_host
  import sleep_ctrl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  sleep_ctrl_if.host       link,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o
);
  import sleep_ctrl_pkg::*;

  host_state_t state;
  logic [11:0] cmd_addr;
  logic [31:0] cmd_wdata;
  logic        cmd_we;
  logic [31:0] rd_word;
  logic        req;
  logic        setup;
  logic        apb_wr;

  assign setup  = psel_i && !penable_i;
  assign apb_wr = psel_i && penable_i && pready_o && pwrite_i;

  // apb answers in the first access cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else begin
      pready_o  <= setup;
      pslverr_o <= 1'b0;
      if (setup && !pwrite_i) begin
        unique case (paddr_i)
          HOFS_ADDR:   prdata_o <= {20'h0_0000, cmd_addr};
          HOFS_WDATA:  prdata_o <= cmd_wdata;
          HOFS_STATUS: prdata_o <= {30'h0000_0000, link.sleep_ctrl_irq, state != H_IDLE};
          HOFS_RDATA:  prdata_o <= rd_word;
          default:     prdata_o <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cmd_addr  <= '0;
      cmd_wdata <= '0;
    end else if (apb_wr && state == H_IDLE) begin
      if (paddr_i == HOFS_ADDR) begin
        cmd_addr <= pwdata_i[11:0];
      end
      if (paddr_i == HOFS_WDATA) begin
        cmd_wdata <= pwdata_i;
      end
    end
  end

  // request held until ack, then a settle cycle while ack drops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state   <= H_IDLE;
      req     <= 1'b0;
      cmd_we  <= 1'b0;
      rd_word <= '0;
    end else begin
      unique case (state)
        H_IDLE: begin
          if (apb_wr && paddr_i == HOFS_CTRL && pwdata_i[HBIT_START]) begin
            cmd_we <= pwdata_i[HBIT_WRITE];
            req    <= 1'b1;
            state  <= H_REQ;
          end
        end
        H_REQ: begin
          if (link.ack) begin
            req <= 1'b0;
            if (!cmd_we) begin
              rd_word <= link.rdata;
            end
            state <= H_DONE;
          end
        end
        H_DONE: begin
          state <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= link.sleep_ctrl_irq;
    end
  end

  assign link.req   = req;
  assign link.we    = cmd_we;
  assign link.addr  = cmd_addr;
  assign link.wdata = cmd_wdata;
endmodule

// File: test/sleep_ctrl_irq_sva.sv
// checks on the register port and interrupt line between the two ends
`timescale 1ns/100ps
module sleep_ctrl_irq_sva
  import sleep_ctrl_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        req,
  input wire logic        we,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        ack,
  input wire logic        sleep_ctrl_irq
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic rd_go;
  logic wr_go;
  assign rd_go = req && !we && !ack;
  assign wr_go = req && we && !ack;
  ack_single_a: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property ((rd_go || wr_go) |=> ack)
    else $error("ack missing one cycle after request");
  ack_cause_a: assert property ($rose(ack) |-> $past(req))
    else $error("ack without request");
  pid_value_a: assert property (rd_go && addr == OFS_PID |=> rdata == {PID_SCHEME, 2'b00,
    PID_FAMILY, PID_RTL, PID_MAJOR, PID_CUSTOM, PID_MINOR})
    else $error("identification word wrong");
  wo_zero_a: assert property (rd_go && (addr == OFS_REEVAL || addr == OFS_MOD_CLR_LO
    || addr == OFS_MOD_CLR_HI || addr == OFS_DOM_CLR || addr == OFS_TRANS_CMD
    || addr == OFS_TRANS_STAT) |=> rdata == 32'h0)
    else $error("write-only or status word not zero");
  hi_reserved_a: assert property (rd_go && addr == OFS_MOD_PEND_HI |=> rdata[31:9] == 23'h0)
    else $error("module pending high reserved bits set");
  dom_reserved_a: assert property (rd_go && addr == OFS_DOM_PEND |=> rdata[31:1] == 31'h0)
    else $error("domain pending reserved bits set");
  reeval_dip_a: assert property (wr_go && addr == OFS_REEVAL && wdata[0]
    |-> ##[1:3] !sleep_ctrl_irq)
    else $error("irq not re-evaluated");
  reeval_zero_a: assert property (wr_go && addr == OFS_REEVAL && !wdata[0] && sleep_ctrl_irq
    |=> sleep_ctrl_irq [*3])
    else $error("zero write disturbed irq");
  cover property ($rose(sleep_ctrl_irq));
  cover property (wr_go && addr == OFS_REEVAL && wdata[0]);
  cover property (rd_go && addr == OFS_MOD_PEND_HI);
endmodule

// File: test/power_sleep_event_interrupt_tb.sv
// bench joining device and host ends, driven over apb
`timescale 1ns/100ps
module power_sleep_event_interrupt_tb;
  import sleep_ctrl_pkg::*;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [31:0] EVT = 32'h0007_0000;
  logic                   clk_i, srst_i, psel, penable, pwrite, dom_evt, ext_evt;
  logic [NUM_MODULES-1:0] inhibit, leave, force_act, mod_en, lrst;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, q;
  logic                   pready, pslverr, irq, irq_d, trans_go;
  int                     failures = 0, checks = 0, drops = 0, gos = 0;
  sleep_ctrl_if bus();
  sleep_ctrl_irq_dev i_sleep_ctrl_irq_dev (.clk_i(clk_i), .srst_i(srst_i), .link(bus),
    .dom_emu_evt_i(dom_evt), .ext_power_evt_i(ext_evt), .inhibit_sleep_i(inhibit),
    .leave_enable_i(leave), .force_active_i(force_act), .module_enabled_i(mod_en),
    .local_reset_evt_i(lrst), .trans_go_o(trans_go));
  sleep_ctrl_irq_host i_sleep_ctrl_irq_host (.clk_i(clk_i), .srst_i(srst_i), .link(bus),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .irq_o(irq));
  sleep_ctrl_irq_sva i_sva (.clk_i(clk_i), .srst_i(srst_i), .req(bus.req), .we(bus.we),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .ack(bus.ack),
    .sleep_ctrl_irq(bus.sleep_ctrl_irq));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // irq falls and go pulses are counted so single-cycle events are not missed
  always @(posedge clk_i) begin
    irq_d <= irq;
    if (irq_d === 1'b1 && irq === 1'b0) drops <= drops + 1;
    if (trans_go === 1'b1) gos <= gos + 1;
  end
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // no cycle budget here; only the watchdog ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one device access through the host command registers
  task automatic dev_op(input logic w, input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, HOFS_ADDR, {20'h0_0000, a});
    apb(1'b1, HOFS_WDATA, d);
    apb(1'b1, HOFS_CTRL, (32'(w) << HBIT_WRITE) | (32'h1 << HBIT_START));
    do begin
      apb(1'b0, HOFS_STATUS, 32'h0);
    end while (q[HBIT_BUSY] !== 1'b0);
    apb(1'b0, HOFS_RDATA, 32'h0);
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    dev_op(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask
  task automatic fire(input logic d, e, input logic [NUM_MODULES-1:0] fa, ih, lr);
    @(posedge clk_i);
    dom_evt <= d;
    ext_evt <= e;
    force_act <= fa;
    inhibit <= ih;
    leave <= ih;
    lrst <= lr;
    @(posedge clk_i);
    {dom_evt, ext_evt} <= 2'b00;
    {force_act, inhibit, leave, lrst} <= '0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic s_reset();
    rd_chk("identification", OFS_PID, {PID_SCHEME, 2'b00, PID_FAMILY, PID_RTL, PID_MAJOR,
           PID_CUSTOM, PID_MINOR}, ALL);
    rd_chk("module pending low", OFS_MOD_PEND_LO, 32'h0, ALL);
    chk("irq idle", 32'h0, {31'h0, irq});
  endtask
  task automatic s_ext();
    fire(1'b0, 1'b1, '0, '0, '0);
    chk("irq on external event", 32'h1, {31'h0, irq});
    rd_chk("domain pending", OFS_DOM_PEND, 32'h1, ALL);
    rd_chk("domain status", OFS_DOM_STAT, 32'h1 << BIT_EXT_STAT, EVT);
    apb(1'b0, HOFS_STATUS, 32'h0);
    chk("host irq flag", 32'h1, {31'h0, q[HBIT_IRQ]});
    dev_op(1'b1, OFS_DOM_CLR, 32'h0);
    rd_chk("domain pending kept", OFS_DOM_PEND, 32'h1, ALL);
    dev_op(1'b1, OFS_DOM_CLR, 32'h1);
    rd_chk("domain pending cleared", OFS_DOM_PEND, 32'h0, ALL);
    rd_chk("domain status cleared", OFS_DOM_STAT, 32'h0, EVT);
    chk("irq after clear", 32'h0, {31'h0, irq});
  endtask
  task automatic s_dom();
    fire(1'b1, 1'b0, '0, '0, '0);
    rd_chk("domain status", OFS_DOM_STAT, 32'h1 << BIT_STATE_STAT, EVT);
    rd_chk("domain pending unenabled", OFS_DOM_PEND, 32'h0, ALL);
    chk("irq unenabled", 32'h0, {31'h0, irq});
    dev_op(1'b1, OFS_DOM_CTRL, 32'h1 << BIT_STATE_EN);
    rd_chk("domain control", OFS_DOM_CTRL, 32'h1 << BIT_STATE_EN, 32'h1 << BIT_STATE_EN);
    fire(1'b1, 1'b0, '0, '0, '0);
    rd_chk("domain pending enabled", OFS_DOM_PEND, 32'h1, ALL);
    dev_op(1'b1, OFS_DOM_CLR, 32'h1);
  endtask
  task automatic s_mod();
    @(posedge clk_i);
    mod_en <= 41'h1 << 34;
    dev_op(1'b1, OFS_MOD_CTRL + 12'h08c, 32'h1 << BIT_STATE_EN);
    dev_op(1'b1, OFS_MOD_CTRL + 12'h088, 32'h1 << BIT_STATE_EN);
    dev_op(1'b1, OFS_MOD_CTRL + 12'h0a0, 32'h1 << BIT_STATE_EN);
    dev_op(1'b1, OFS_MOD_CTRL + 12'h008, 32'h1 << BIT_RESET_EN);
    fire(1'b0, 1'b0, (41'h1 << 35) | (41'h1 << 34), 41'h1 << 40, 41'h1 << 2);
    rd_chk("module pending high", OFS_MOD_PEND_HI, 32'h0000_0108, ALL);
    rd_chk("module pending low", OFS_MOD_PEND_LO, 32'h0000_0004, ALL);
    rd_chk("module 35 status", OFS_MOD_STAT + 12'h08c, 32'h1 << BIT_STATE_STAT, EVT);
    rd_chk("module 34 status", OFS_MOD_STAT + 12'h088, 32'h0, EVT);
    rd_chk("module 2 status", OFS_MOD_STAT + 12'h008, 32'h1 << BIT_RESET_STAT, EVT);
    chk("irq on module events", 32'h1, {31'h0, irq});
    dev_op(1'b1, OFS_MOD_CLR_HI, 32'h0000_0008);
    rd_chk("pending high after clear", OFS_MOD_PEND_HI, 32'h0000_0100, ALL);
    rd_chk("module 35 status cleared", OFS_MOD_STAT + 12'h08c, 32'h0, EVT);
    dev_op(1'b1, OFS_MOD_CLR_HI, 32'h0000_0100);
    dev_op(1'b1, OFS_MOD_CLR_LO, 32'h0000_0004);
    chk("irq after module clears", 32'h0, {31'h0, irq});
  endtask
  task automatic s_reeval();
    int n0;
    fire(1'b0, 1'b1, '0, '0, '0);
    n0 = drops;
    dev_op(1'b1, OFS_REEVAL, 32'h0);
    chk("irq falls on zero write", 32'(n0), 32'(drops));
    dev_op(1'b1, OFS_REEVAL, 32'h1);
    chk("irq falls on evaluate", 32'(n0 + 1), 32'(drops));
    chk("irq back after evaluate", 32'h1, {31'h0, irq});
    dev_op(1'b1, OFS_DOM_CLR, 32'h1);
    dev_op(1'b1, OFS_REEVAL, 32'h1);
    chk("irq quiet after evaluate", 32'h0, {31'h0, irq});
    chk("irq falls total", 32'(n0 + 2), 32'(drops));
  endtask
  task automatic s_misc();
    int g;
    g = gos;
    dev_op(1'b1, OFS_TRANS_CMD, 32'h0);
    chk("go pulses on zero", 32'(g), 32'(gos));
    dev_op(1'b1, OFS_TRANS_CMD, 32'h1);
    chk("go pulses", 32'(g + 1), 32'(gos));
    rd_chk("transition status", OFS_TRANS_STAT, 32'h0, ALL);
    rd_chk("clear reads zero", OFS_DOM_CLR, 32'h0, ALL);
    dev_op(1'b1, 12'h7f0, 32'hffff_ffff);
    rd_chk("unmapped word", 12'h7f0, 32'h0, ALL);
    chk("slave error", 32'h0, {31'h0, pslverr});
  endtask
  initial begin
    {psel, penable, pwrite, dom_evt, ext_evt} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {inhibit, leave, force_act, mod_en, lrst} = '0;
    srst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    s_reset();
    s_ext();
    s_dom();
    s_mod();
    s_reeval();
    s_misc();
    close_out();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    failures++;
    close_out();
  end
endmodule
